/* File: common/pmc_regs.svh */
// register offsets, field masks, reset values of the port configuration block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// offsets from the configuration space base
`define PMC_OFF_MODE_A   8'h00
`define PMC_OFF_MODE_B   8'h01
`define PMC_OFF_DIR_A    8'h04
`define PMC_OFF_DIR_B    8'h05
`define PMC_OFF_DIR_C    8'h06
`define PMC_OFF_DIR_D    8'h07
`define PMC_OFF_DRV_A    8'h08
`define PMC_OFF_DRV_B    8'h09
`define PMC_OFF_DRV_C    8'h0a
`define PMC_OFF_DRV_D    8'h0b

// power-up value of every configuration register
`define PMC_CFG_RESET    8'h00

// implemented bits per port
`define PMC_IMPL_AB      8'hff
`define PMC_IMPL_C       8'hff
`define PMC_IMPL_D       8'h06

// drive-select meaning per port
`define PMC_OD_AB        8'hf0
`define PMC_SLEW_AB      8'h0f
`define PMC_OD_C         8'h9c
`define PMC_SLEW_C       8'h00
`define PMC_OD_D         8'h00
`define PMC_SLEW_D       8'h06

// second macrocell group reaches only these port c pins
`define PMC_BC_C_PINS    8'h9c

// dedicated test access pins on port c
`define PMC_JTAG_TMS     0
`define PMC_JTAG_TCK     1
`define PMC_JTAG_TDI     5
`define PMC_JTAG_TDO     6
`define PMC_JTAG_PINS    8'h63

// port indices
`define PMC_PORT_A       0
`define PMC_PORT_B       1
`define PMC_PORT_C       2
`define PMC_PORT_D       3

`endif

/* File: common/pmc_pkg.sv */
// types shared by the port configuration block
package pmc_pkg;

    // configuration of one port
    typedef struct packed {
        logic [7:0] mode;   // 0 mcu i/o, 1 address out
        logic [7:0] dir;    // 1 output, 0 input
        logic [7:0] drive;  // open drain or fast slew
    } pmc_cfg_s;

    // pad-facing signals of one port
    typedef struct packed {
        logic [7:0] out;    // level to drive
        logic [7:0] oe;     // high while driving
        logic [7:0] fast;   // fast slew select
    } pmc_pin_s;

    // macrocell routing selects per pin
    typedef struct packed {
        logic [7:0] ab_to_a;
        logic [7:0] ab_to_b;
        logic [7:0] bc_to_b;
        logic [7:0] bc_to_c;
    } pmc_route_s;

endpackage

/* File: rtl/pmc_port_pin.sv */
// one port's output multiplexer, direction and driver selection
`timescale 1ns/10ps
`include "pmc_regs.svh"

module pmc_port_pin #(
    parameter logic [7:0] IMPL     = 8'hff,  // implemented pins
    parameter logic [7:0] OD_MASK  = 8'h00,  // pins with open drain
    parameter logic [7:0] SLEW_MSK = 8'h00,  // pins with slew control
    parameter bit         HAS_MODE = 1'b0    // address out available
) (
    input  wire pmc_pkg::pmc_cfg_s cfg_i,
    input  wire logic [7:0]        oe_term_i,
    input  wire logic [7:0]        data_out_i,
    input  wire logic [7:0]        mcell_i,
    input  wire logic [7:0]        mcell_sel_i,
    input  wire logic [7:0]        addr_i,
    output pmc_pkg::pmc_pin_s      pin_o
);

    // ==========================================================
    // pin logic
    // ==========================================================
    logic [7:0] en;        // driver enable before open drain
    logic [7:0] addr_use;  // pin shows latched address
    logic [7:0] val;       // selected output level
    logic [7:0] od;        // open drain active

    // direction bit or output enable term makes an output
    assign en = (cfg_i.dir | oe_term_i) & IMPL;
    // address out needs mode bit and either enable source
    assign addr_use = HAS_MODE ? (cfg_i.mode & en) : 8'h00;

    // per bit mux: macrocell, then address, then data out
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (mcell_sel_i[i]) begin
                val[i] = mcell_i[i];
            end else if (addr_use[i]) begin
                val[i] = addr_i[i];
            end else begin
                val[i] = data_out_i[i];
            end
        end
    end

    // open drain only pulls low; the pull-up is off chip
    assign od = cfg_i.drive & OD_MASK;
    assign pin_o.out = val & ~od & IMPL;
    assign pin_o.oe = en & ~(od & val);
    assign pin_o.fast = cfg_i.drive & SLEW_MSK & IMPL;

endmodule

/* File: rtl/pmc_port_config.sv */
// port configuration registers, pin muxing and peripheral buffer
// Operation
// - memory mode bit seven makes port a buffer
// - select terms enable the peripheral buffer
// - either select term low floats port a
// - program store strobe gates the buffer
// - port c carries four dedicated test pins
// - macrocell groups reach only their ports
// - address out puts a7-a0 on pins
// - address out needs mode plus enable term or direction
// - mcu reads and writes config registers
// - each bit configures its own pin
// - configuration registers reset to zero
// - mode bit selects mcu i/o or address
// - direction one output, zero input, default input
// - direction ored with output enable term
// - port d direction has two bits
// - port d uses only bits two and one
// - drive bit one selects open drain
// - drive bit one selects fast slew
// - drive bit meaning fixed per port pin
// - data out drives pins when enabled
`timescale 1ns/10ps
`include "pmc_regs.svh"

module pmc_port_config #(
    parameter int  PORT_W   = 8,     // pins per port
    parameter bit  USE_PROGRAM_STORE_STROBE = 1'b1   // gate buffer with strobe
) (
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    // mcu bus into configuration space
    input  wire logic                    cfg_sel_i,
    input  wire logic [7:0]              mcu_addr_i,
    input  wire logic [7:0]              mcu_wdata_i,
    input  wire logic                    mcu_wr_i,
    input  wire logic                    mcu_rd_i,
    output logic      [7:0]              mcu_rdata_o,
    output logic                         mcu_rdata_valid_o,
    // peripheral i/o controls
    input  wire logic                    peripheral_buffer_enable_bit_i,
    input  wire logic                    peripheral_select_term_0_i,
    input  wire logic                    peripheral_select_term_1_i,
    input  wire logic                    program_store_strobe_i,
    // logic array and data register sources
    input  wire logic [3:0][7:0]         oe_term_i,
    input  wire logic [3:0][7:0]         data_out_i,
    input  wire logic [7:0]              latched_addr_i,
    input  wire logic [7:0]              first_macrocell_group_i,
    input  wire logic [7:0]              second_macrocell_group_i,
    input  wire pmc_pkg::pmc_route_s     route_i,
    // test access port on port c
    input  wire logic                    jtag_tdo_i,
    input  wire logic                    jtag_tdo_oe_i,
    output logic                         jtag_tms_o,
    output logic                         jtag_tck_o,
    output logic                         jtag_tdi_o,
    // pads
    input  wire logic [3:0][7:0]         pin_in_i,
    output pmc_pkg::pmc_pin_s [3:0]      pins_o
);

    // ==========================================================
    // elaboration checks
    // ==========================================================
    // the register map and masks assume eight pin ports
    if (PORT_W != 8) begin : g_bad_width
        $error("pmc_port_config: PORT_W must be 8");
    end

    // ==========================================================
    // configuration registers
    // ==========================================================
    logic [1:0][7:0] mode_reg;   // ports a and b only
    logic [3:0][7:0] dir_reg;    // all four ports
    logic [3:0][7:0] drive_reg;  // all four ports
    logic            wr_hit;     // write to configuration space
    logic            rd_hit;     // read of configuration space

    // implemented bit mask per port index
    function automatic logic [7:0] impl_mask(input int p);
        logic [7:0] m;
        m = `PMC_IMPL_AB;
        if (p == `PMC_PORT_C) begin
            m = `PMC_IMPL_C;
        end else if (p == `PMC_PORT_D) begin
            m = `PMC_IMPL_D;
        end
        return m;
    endfunction

    // a strobe outside configuration space never lands here
    assign wr_hit = cfg_sel_i & mcu_wr_i;
    assign rd_hit = cfg_sel_i & mcu_rd_i;

    // mode-select registers exist for ports a and b only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg <= {2{`PMC_CFG_RESET}};
        end else if (wr_hit) begin
            // one register per port, bit i steers pin i
            if (mcu_addr_i == `PMC_OFF_MODE_A) begin
                mode_reg[0] <= mcu_wdata_i;
            end
            if (mcu_addr_i == `PMC_OFF_MODE_B) begin
                mode_reg[1] <= mcu_wdata_i;
            end
        end
    end

    // direction registers; unused port d bits stay zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_reg <= {4{`PMC_CFG_RESET}};
        end else if (wr_hit) begin
            for (int p = 0; p < 4; p++) begin
                if (mcu_addr_i == `PMC_OFF_DIR_A + 8'(p)) begin
                    dir_reg[p] <= mcu_wdata_i & impl_mask(p);
                end
            end
        end
    end

    // drive-select registers; unused port d bits stay zero
    // not-applicable bits elsewhere are kept and read back as written
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drive_reg <= {4{`PMC_CFG_RESET}};
        end else if (wr_hit) begin
            for (int p = 0; p < 4; p++) begin
                if (mcu_addr_i == `PMC_OFF_DRV_A + 8'(p)) begin
                    drive_reg[p] <= mcu_wdata_i & impl_mask(p);
                end
            end
        end
    end

    // ==========================================================
    // peripheral buffer control
    // ==========================================================
    logic periph_mode;  // port a handed to the mcu data bus
    logic periph_sel;   // buffer open this cycle
    logic program_store_strobe_gate;    // strobe qualifier

    // strobe gating keeps the buffer shut in data space
    assign program_store_strobe_gate = USE_PROGRAM_STORE_STROBE ? program_store_strobe_i : 1'b1;
    assign periph_mode = peripheral_buffer_enable_bit_i;
    // both select terms must be high, any low one floats
    assign periph_sel = periph_mode
                      & peripheral_select_term_0_i
                      & peripheral_select_term_1_i
                      & program_store_strobe_gate;

    // ==========================================================
    // read path
    // ==========================================================
    logic [7:0] rd_value;  // selected read data
    logic       rd_any;    // some read is answered

    // buffered pin read wins over a configuration read
    always_comb begin
        rd_value = 8'h00;
        rd_any = 1'b0;
        if (periph_sel && mcu_rd_i) begin
            rd_value = pin_in_i[`PMC_PORT_A];
            rd_any = 1'b1;
        end else if (rd_hit) begin
            rd_any = 1'b1;
            unique case (mcu_addr_i)
                `PMC_OFF_MODE_A: rd_value = mode_reg[0];
                `PMC_OFF_MODE_B: rd_value = mode_reg[1];
                `PMC_OFF_DIR_A:  rd_value = dir_reg[0];
                `PMC_OFF_DIR_B:  rd_value = dir_reg[1];
                `PMC_OFF_DIR_C:  rd_value = dir_reg[2];
                `PMC_OFF_DIR_D:  rd_value = dir_reg[3];
                `PMC_OFF_DRV_A:  rd_value = drive_reg[0];
                `PMC_OFF_DRV_B:  rd_value = drive_reg[1];
                `PMC_OFF_DRV_C:  rd_value = drive_reg[2];
                `PMC_OFF_DRV_D:  rd_value = drive_reg[3];
                // unmapped offsets answer zero
                default:         rd_value = 8'h00;
            endcase
        end
    end

    // read data is registered, one cycle after the strobe
    // rdata keeps its last value between reads
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mcu_rdata_o <= 8'h00;
            mcu_rdata_valid_o <= 1'b0;
        end else begin
            mcu_rdata_valid_o <= rd_any;
            if (rd_any) begin
                mcu_rdata_o <= rd_value;
            end
        end
    end

    // ==========================================================
    // per port pin logic
    // ==========================================================
    pmc_pkg::pmc_pin_s [3:0] pin_next;  // combinational pad values
    pmc_pkg::pmc_cfg_s [3:0] cfg;       // bundled configuration
    logic [3:0][7:0]         msel;      // macrocell route per pin
    logic [3:0][7:0]         mval;      // macrocell value per pin

    // ports c and d have no mode register, tie to mcu i/o
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            cfg[p].mode = (p < 2) ? mode_reg[1'(p)] : 8'h00;
            cfg[p].dir = dir_reg[p];
            cfg[p].drive = drive_reg[p];
        end
    end

    // port b can take either group; the second group wins
    always_comb begin
        msel[0] = route_i.ab_to_a;
        mval[0] = first_macrocell_group_i;
        msel[1] = route_i.ab_to_b | route_i.bc_to_b;
        // per pin choice, so a partial second route keeps the first
        mval[1] = (route_i.bc_to_b & second_macrocell_group_i)
                | (~route_i.bc_to_b & first_macrocell_group_i);
        // second group reaches only four port c pins
        msel[2] = route_i.bc_to_c & `PMC_BC_C_PINS
                & ~`PMC_JTAG_PINS;
        mval[2] = second_macrocell_group_i;
        msel[3] = 8'h00;
        mval[3] = 8'h00;
    end

    // one instance per port, ports a and b share masks, c and d differ
    pmc_port_pin #(
        .IMPL     (`PMC_IMPL_AB),
        .OD_MASK  (`PMC_OD_AB),
        .SLEW_MSK (`PMC_SLEW_AB),
        .HAS_MODE (1'b1)
    ) u_port_a (
        .cfg_i      (cfg[0]),
        .oe_term_i  (oe_term_i[0]),
        .data_out_i (data_out_i[0]),
        .mcell_i    (mval[0]),
        .mcell_sel_i(msel[0]),
        .addr_i     (latched_addr_i),
        .pin_o      (pin_next[0])
    );

    pmc_port_pin #(
        .IMPL     (`PMC_IMPL_AB),
        .OD_MASK  (`PMC_OD_AB),
        .SLEW_MSK (`PMC_SLEW_AB),
        .HAS_MODE (1'b1)
    ) u_port_b (
        .cfg_i      (cfg[1]),
        .oe_term_i  (oe_term_i[1]),
        .data_out_i (data_out_i[1]),
        .mcell_i    (mval[1]),
        .mcell_sel_i(msel[1]),
        .addr_i     (latched_addr_i),
        .pin_o      (pin_next[1])
    );

    pmc_port_pin #(
        .IMPL     (`PMC_IMPL_C),
        .OD_MASK  (`PMC_OD_C),
        .SLEW_MSK (`PMC_SLEW_C),
        .HAS_MODE (1'b0)
    ) u_port_c (
        .cfg_i      (cfg[2]),
        .oe_term_i  (oe_term_i[2]),
        .data_out_i (data_out_i[2]),
        .mcell_i    (mval[2]),
        .mcell_sel_i(msel[2]),
        .addr_i     (8'h00),
        .pin_o      (pin_next[2])
    );

    // port d direction has no logic array enable term
    pmc_port_pin #(
        .IMPL     (`PMC_IMPL_D),
        .OD_MASK  (`PMC_OD_D),
        .SLEW_MSK (`PMC_SLEW_D),
        .HAS_MODE (1'b0)
    ) u_port_d (
        .cfg_i      (cfg[3]),
        .oe_term_i  (8'h00),
        .data_out_i (data_out_i[3]),
        .mcell_i    (mval[3]),
        .mcell_sel_i(msel[3]),
        .addr_i     (8'h00),
        .pin_o      (pin_next[3])
    );

    // ==========================================================
    // pad registers with port overrides
    // ==========================================================
    pmc_pkg::pmc_pin_s [3:0] pad_next;  // after overrides

    always_comb begin
        pad_next = pin_next;
        // port a as a bus buffer drives only during writes
        if (periph_mode) begin
            pad_next[0].out = mcu_wdata_i;
            pad_next[0].oe = {8{periph_sel & mcu_wr_i}};
            pad_next[0].fast = 8'h00;
        end
        // test pins are dedicated, configuration has no say
        pad_next[2].out = pin_next[2].out & ~`PMC_JTAG_PINS;
        pad_next[2].oe = pin_next[2].oe & ~`PMC_JTAG_PINS;
        pad_next[2].fast = 8'h00;
        pad_next[2].out[`PMC_JTAG_TDO] = jtag_tdo_i;
        pad_next[2].oe[`PMC_JTAG_TDO] = jtag_tdo_oe_i;
    end

    // pad outputs come from flip-flops, one cycle behind
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_o <= '0;
        end else begin
            pins_o <= pad_next;
        end
    end

    // test inputs are taken straight from their pads
    // one stage only, the pads count as synchronous to clk_i
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            jtag_tms_o <= 1'b0;
            jtag_tck_o <= 1'b0;
            jtag_tdi_o <= 1'b0;
        end else begin
            jtag_tms_o <= pin_in_i[2][`PMC_JTAG_TMS];
            jtag_tck_o <= pin_in_i[2][`PMC_JTAG_TCK];
            jtag_tdi_o <= pin_in_i[2][`PMC_JTAG_TDI];
        end
    end

endmodule

/* File: dv/pmc_port_config_asserts.sv */
// concurrent checks on the port configuration block ports
`timescale 1ns/10ps

module pmc_port_config_asserts #(
    parameter bit USE_PROGRAM_STORE_STROBE = 1'b1  // strobe gates the buffer
) (
    input wire logic                 clk_i,
    input wire logic                 reset_n_i,
    input wire logic                 cfg_sel_i,
    input wire logic [7:0]           mcu_wdata_i,
    input wire logic                 mcu_wr_i,
    input wire logic                 mcu_rd_i,
    input wire logic [7:0]           mcu_rdata_o,
    input wire logic                 mcu_rdata_valid_o,
    input wire logic                 peripheral_buffer_enable_bit_i,
    input wire logic                 peripheral_select_term_0_i,
    input wire logic                 peripheral_select_term_1_i,
    input wire logic                 program_store_strobe_i,
    input wire logic                 jtag_tdo_i,
    input wire logic                 jtag_tdo_oe_i,
    input wire logic                 jtag_tms_o,
    input wire logic                 jtag_tck_o,
    input wire logic                 jtag_tdi_o,
    input wire logic [3:0][7:0]      pin_in_i,
    input wire pmc_pkg::pmc_pin_s [3:0] pins_o
);
    // ====================
    // helper terms
    logic psel;    // peripheral buffer selected
    logic rd_any;  // read that must answer
    assign psel = peripheral_buffer_enable_bit_i
        && peripheral_select_term_0_i && peripheral_select_term_1_i
        && (program_store_strobe_i || !USE_PROGRAM_STORE_STROBE);
    assign rd_any = mcu_rd_i && (cfg_sel_i || psel);

    // one clock domain, so one default
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // ====================
    // assertions
    a_rd_valid_set: assert property (
        rd_any |=> mcu_rdata_valid_o) else $error("read gave no valid");
    a_rd_valid_clr: assert property (
        !rd_any |=> !mcu_rdata_valid_o) else $error("valid without read");
    a_pio_drive: assert property (
        psel && mcu_wr_i |=> pins_o[0].oe == 8'hff
            && pins_o[0].out == $past(mcu_wdata_i))
        else $error("buffer write not driven");
    a_pio_float: assert property (
        peripheral_buffer_enable_bit_i && !(psel && mcu_wr_i)
            |=> pins_o[0].oe == 8'h00) else $error("buffer not floated");
    a_pio_read: assert property (
        psel && mcu_rd_i |=> mcu_rdata_o == $past(pin_in_i[0]))
        else $error("buffer read wrong");
    // first edge after reset still sees reset-time inputs
    a_jtag_copy: assert property (
        $past(reset_n_i) |-> jtag_tms_o == $past(pin_in_i[2][0])
            && jtag_tck_o == $past(pin_in_i[2][1])
            && jtag_tdi_o == $past(pin_in_i[2][5]))
        else $error("test inputs not copied");
    a_jtag_tdo: assert property (
        $past(reset_n_i) |-> pins_o[2].oe[6] == $past(jtag_tdo_oe_i)
            && (!pins_o[2].oe[6] || pins_o[2].out[6] == $past(jtag_tdo_i))
            && (pins_o[2].oe & 8'h23) == 8'h00)
        else $error("test pins misdriven");
    a_port_d_bits: assert property (
        ((pins_o[3].oe | pins_o[3].fast) & 8'hf9) == 8'h00)
        else $error("port d unused pin active");
    a_slew_bits: assert property (
        pins_o[2].fast == 8'h00 && pins_o[1].fast[7:4] == 4'h0
            && pins_o[0].fast[7:4] == 4'h0) else $error("slew on wrong pin");
endmodule

bind pmc_port_config pmc_port_config_asserts #(.USE_PROGRAM_STORE_STROBE(USE_PROGRAM_STORE_STROBE)) u_chk (
    .clk_i, .reset_n_i, .cfg_sel_i, .mcu_wdata_i, .mcu_wr_i, .mcu_rd_i,
    .mcu_rdata_o, .mcu_rdata_valid_o, .peripheral_buffer_enable_bit_i,
    .peripheral_select_term_0_i, .peripheral_select_term_1_i,
    .program_store_strobe_i, .jtag_tdo_i, .jtag_tdo_oe_i, .jtag_tms_o,
    .jtag_tck_o, .jtag_tdi_o, .pin_in_i, .pins_o);

/* File: dv/pmc_periph_model.sv */
// external peripherals seen through the port pads
`timescale 1ns/10ps

module pmc_periph_model (
    input  wire pmc_pkg::pmc_pin_s [3:0] pins_i,   // device pad drive
    input  wire logic [3:0][7:0]         ext_i,    // peripheral levels
    output logic [3:0][7:0]              pin_in_o  // resolved pad level
);
    // device wins where it drives, else the peripheral or pull-up
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            pin_in_o[p] = (pins_i[p].oe & pins_i[p].out)
                | (~pins_i[p].oe & ext_i[p]);
        end
    end
endmodule

/* File: dv/pmc_port_config_tb.sv */
// self-checking testbench of the port configuration block
`timescale 1ns/10ps
`include "pmc_regs.svh"

module pmc_port_config_tb;
    // ====================
    // one ordinary case: write, then expected pads
    typedef struct packed {
        logic [7:0] addr;   // register written
        logic [7:0] wdata;  // value written
        logic [7:0] rb;     // value read back
        logic [1:0] port;   // port observed
        logic [7:0] oe;     // pad enables
        logic [7:0] out;    // driven levels
        logic [7:0] fast;   // fast slew pins
    } pmc_row_s;
    logic clk, reset_n, cfg_sel, wr, rd, peripheral_buffer_enable_bit, ps0, ps1, program_store_strobe, tdo, tdo_oe;
    logic                    valid, tms, tck, tdi;
    logic [7:0]              addr, wdata, laddr, mc1, mc2, rdata, got;
    logic [3:0][7:0]         oe_term, data_out, ext, pin_in;
    pmc_pkg::pmc_route_s     route;
    pmc_pkg::pmc_pin_s [3:0] pins;
    int                      err_total = 0;
    int                      tests_run = 0;
    // rows run in order, each builds on the last
    pmc_row_s rows [12] = '{
        '{`PMC_OFF_DIR_A, 8'h07, 8'h07, 2'h0, 8'h07, 8'h02, 8'h00},
        '{`PMC_OFF_DRV_A, 8'h0f, 8'h0f, 2'h0, 8'h07, 8'h02, 8'h0f},
        '{`PMC_OFF_DIR_A, 8'hff, 8'hff, 2'h0, 8'hff, 8'h5a, 8'h0f},
        '{`PMC_OFF_DRV_A, 8'hf0, 8'hf0, 2'h0, 8'haf, 8'h0a, 8'h00},
        '{`PMC_OFF_MODE_A, 8'h0f, 8'h0f, 2'h0, 8'haf, 8'h0c, 8'h00},
        '{`PMC_OFF_DIR_B, 8'h3c, 8'h3c, 2'h1, 8'h3c, 8'h00, 8'h00},
        '{`PMC_OFF_MODE_B, 8'hf0, 8'hf0, 2'h1, 8'h3c, 8'h30, 8'h00},
        '{`PMC_OFF_DIR_C, 8'hff, 8'hff, 2'h2, 8'h9c, 8'h94, 8'h00},
        '{`PMC_OFF_DRV_C, 8'hff, 8'hff, 2'h2, 8'h08, 8'h00, 8'h00},
        '{`PMC_OFF_DIR_D, 8'hff, 8'h06, 2'h3, 8'h06, 8'h06, 8'h00},
        '{`PMC_OFF_DRV_D, 8'hff, 8'h06, 2'h3, 8'h06, 8'h06, 8'h06},
        '{8'h0f, 8'hff, 8'h00, 2'h3, 8'h06, 8'h06, 8'h06}};
    logic [7:0] offs [10] = '{`PMC_OFF_MODE_A, `PMC_OFF_MODE_B,
        `PMC_OFF_DIR_A, `PMC_OFF_DIR_B, `PMC_OFF_DIR_C, `PMC_OFF_DIR_D,
        `PMC_OFF_DRV_A, `PMC_OFF_DRV_B, `PMC_OFF_DRV_C, `PMC_OFF_DRV_D};

    pmc_port_config u_pmc_port_config (
        .clk_i(clk), .reset_n_i(reset_n), .cfg_sel_i(cfg_sel),
        .mcu_addr_i(addr), .mcu_wdata_i(wdata), .mcu_wr_i(wr),
        .mcu_rd_i(rd), .mcu_rdata_o(rdata), .mcu_rdata_valid_o(valid),
        .peripheral_buffer_enable_bit_i(peripheral_buffer_enable_bit),
        .peripheral_select_term_0_i(ps0), .peripheral_select_term_1_i(ps1),
        .program_store_strobe_i(program_store_strobe), .oe_term_i(oe_term),
        .data_out_i(data_out), .latched_addr_i(laddr),
        .first_macrocell_group_i(mc1), .second_macrocell_group_i(mc2),
        .route_i(route), .jtag_tdo_i(tdo), .jtag_tdo_oe_i(tdo_oe),
        .jtag_tms_o(tms), .jtag_tck_o(tck), .jtag_tdi_o(tdi),
        .pin_in_i(pin_in), .pins_o(pins));
    pmc_periph_model u_pmc_periph_model (
        .pins_i(pins), .ext_i(ext), .pin_in_o(pin_in));

    // 200 mhz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ====================
    // tasks
    task automatic chk8(input string name, input logic [7:0] exp, seen);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // pads are registered behind the registers
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic cfg_wr(input logic [7:0] a, d);
        @(posedge clk);
        cfg_sel <= 1'b1;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        cfg_sel <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_sel <= 1'b1;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        cfg_sel <= 1'b0;
        rd <= 1'b0;
        #1;
        chk8("read valid", 8'h01, {7'h00, valid});
        d = rdata;
    endtask
    task automatic pad(input int p, input logic [7:0] oe, out);
        chk8("pad oe", oe, pins[p].oe);
        chk8("pad out", out, pins[p].out & pins[p].oe);
    endtask
    task automatic reg_zero;
        for (int i = 0; i < 10; i++) begin
            cfg_rd(offs[i], got);
            chk8("reset value", `PMC_CFG_RESET, got);
        end
        chk8("reset oe", 8'h00, pins[0].oe);
        $display("test reset done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ====================
    // main sequence
    initial begin
        {reset_n, cfg_sel, wr, rd, peripheral_buffer_enable_bit, ps0, ps1, program_store_strobe, tdo, tdo_oe} = '0;
        {addr, wdata, mc1, mc2, oe_term, ext, route} = '0;
        data_out = {8'hff, 8'h96, 8'hc3, 8'h5a};
        laddr = 8'h3c;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        reg_zero();
        foreach (rows[i]) begin
            cfg_wr(rows[i].addr, rows[i].wdata);
            settle();
            pad(rows[i].port, rows[i].oe, rows[i].out);
            chk8("fast", rows[i].fast, pins[rows[i].port].fast);
            cfg_rd(rows[i].addr, got);
            chk8("readback", rows[i].rb, got);
        end
        $display("test rows done");
        // logic-array enable joins direction, address out wakes up
        @(posedge clk);
        oe_term[1] <= 8'hc0;
        settle();
        pad(1, 8'hfc, 8'h30);
        // macrocell routes win over address out, chosen pin by pin
        cfg_wr(`PMC_OFF_DRV_C, 8'h00);
        route <= '{8'h00, 8'h0c, 8'hc0, 8'hff};
        mc2 <= 8'hff;
        settle();
        pad(1, 8'hfc, 8'hf0);
        pad(2, 8'h9c, 8'h9c);
        @(posedge clk);
        tdo_oe <= 1'b1;
        tdo <= 1'b1;
        ext[2] <= 8'h23;
        settle();
        pad(2, 8'hdc, 8'hdc);
        chk8("test pins", 8'h07, {5'h00, tms, tck, tdi});
        $display("test routes done");
        // peripheral buffer write, idle, read, then refusals
        @(posedge clk);
        {peripheral_buffer_enable_bit, ps0, ps1, program_store_strobe, wr} <= 5'h1f;
        wdata <= 8'ha5;
        ext[0] <= 8'h3c;
        settle();
        pad(0, 8'hff, 8'ha5);
        @(posedge clk);
        wr <= 1'b0;
        settle();
        pad(0, 8'h00, 8'h00);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8("buffer read", 8'h3c, rdata);
        chk8("buffer valid", 8'h01, {7'h00, valid});
        @(posedge clk);
        {program_store_strobe, wr} <= 2'h1;
        settle();
        pad(0, 8'h00, 8'h00);
        @(posedge clk);
        {program_store_strobe, ps1} <= 2'h2;
        settle();
        pad(0, 8'h00, 8'h00);
        @(posedge clk);
        {peripheral_buffer_enable_bit, wr, ps1} <= 3'h1;
        $display("test buffer done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_zero();
        conclude();
    end

    // hang guard, well past the expected run length
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        $display("[FAIL] watchdog expected done seen hang");
        conclude();
    end
endmodule
